// [rtl/pv_map_pkg.sv]
// Constants, address table and types for the process-value Modbus map
package pv_map_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned LOCK_TIMEOUT_S = 30;
   localparam int unsigned LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_S * CLK_HZ;

   // ************************************************************
   // Function and exception codes
   // ************************************************************
   localparam logic [7:0] FN_READ_BITS = 8'h01;
   localparam logic [7:0] FN_READ_INBITS = 8'h02;
   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam logic [7:0] FN_READ_INPUT = 8'h04;
   localparam logic [7:0] FN_WRITE_BIT = 8'h05;
   localparam logic [7:0] FN_WRITE_REG = 8'h06;
   localparam logic [7:0] FN_WRITE_BITS = 8'h0F;
   localparam logic [7:0] FN_WRITE_REGS = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_LOCKED = 8'h04;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;

   // ************************************************************
   // Program window used for unlocking
   // ************************************************************
   localparam logic [15:0] PROG_ID_ADDR = 16'h0050;
   localparam logic [15:0] PROG_PASS_ADDR = 16'h0051;
   localparam logic [15:0] UNLOCK_CODE = 16'h0001;

   // ************************************************************
   // Kinds, formats and counts
   // ************************************************************
   localparam logic [2:0] K_CHAN = 3'h0;
   localparam logic [2:0] K_TOTAL = 3'h1;
   localparam logic [2:0] K_TIMER = 3'h2;
   localparam logic [2:0] K_ALARM = 3'h3;
   localparam logic [2:0] K_OUT = 3'h4;
   localparam logic [2:0] K_IN = 3'h5;
   localparam logic [2:0] K_PROG = 3'h6;
   localparam logic [2:0] FMT_SHORT = 3'h0;
   localparam logic [2:0] FMT_BIT = 3'h1;
   localparam logic [2:0] FMT_LONG = 3'h2;
   localparam logic [2:0] FMT_FLOAT = 3'h3;
   localparam logic [2:0] FMT_DOUBLE = 3'h4;
   localparam logic [2:0] FMT_LLONG = 3'h5;
   localparam logic [7:0] CHAN_COUNT = 8'h63;
   localparam logic [7:0] TOTAL_COUNT = 8'h20;
   localparam logic [7:0] TIMER_COUNT = 8'h20;
   localparam logic [7:0] ALARM_COUNT = 8'h40;
   localparam logic [7:0] OUT_COUNT = 8'h40;
   localparam logic [7:0] IN_COUNT = 8'hC7;
   localparam logic [1:0] ALARM_OFF = 2'h0;
   localparam logic [1:0] ALARM_ON = 2'h1;
   localparam logic [1:0] ALARM_ON_ACK = 2'h2;

   // ************************************************************
   // Address table: base, kind, format, stride shift
   // ************************************************************
   localparam int ROWS = 25;
   localparam logic [15:0] ROW_BASE [ROWS] = '{
      16'h0064, 16'h00C8, 16'h0190, 16'h0258, 16'h03E8,
      16'h0834, 16'h0898, 16'h08FC, 16'h0960, 16'h0A28,
      16'h0C1C, 16'h0C80, 16'h0CE4, 16'h0D48, 16'h0E10,
      16'h1004, 16'h1068, 16'h1130, 16'h11F8, 16'h1388,
      16'h17D4, 16'h189C, 16'h1A2C, 16'h1BBC, 16'h1EDC};
   localparam logic [2:0] ROW_KIND [ROWS] = '{
      K_CHAN, K_CHAN, K_CHAN, K_CHAN, K_CHAN,
      K_TOTAL, K_TOTAL, K_TOTAL, K_TOTAL, K_TOTAL,
      K_TIMER, K_TIMER, K_TIMER, K_TIMER, K_ALARM,
      K_OUT, K_OUT, K_OUT, K_OUT, K_OUT,
      K_IN, K_IN, K_IN, K_IN, K_IN};
   localparam logic [2:0] ROW_FMT [ROWS] = '{
      FMT_SHORT, FMT_LONG, FMT_FLOAT, FMT_DOUBLE, FMT_LLONG,
      FMT_SHORT, FMT_LONG, FMT_FLOAT, FMT_DOUBLE, FMT_LLONG,
      FMT_SHORT, FMT_LONG, FMT_FLOAT, FMT_DOUBLE, FMT_SHORT,
      FMT_SHORT, FMT_LONG, FMT_FLOAT, FMT_DOUBLE, FMT_LLONG,
      FMT_SHORT, FMT_LONG, FMT_FLOAT, FMT_DOUBLE, FMT_LLONG};
   localparam int BIT_ROWS = 3;
   localparam logic [15:0] BIT_BASE [BIT_ROWS] = '{
      16'h0064, 16'h1004, 16'h17D4};
   localparam logic [2:0] BIT_KIND [BIT_ROWS] = '{K_CHAN, K_OUT, K_IN};

   typedef enum logic [0:0] {
      PH_IDLE = 1'b0,
      PH_FETCH = 1'b1
   } phase_t;

   // Word stride of a format as a shift
   function automatic logic [1:0] fmt_shift(input logic [2:0] fmt);
      if (fmt == FMT_DOUBLE || fmt == FMT_LLONG) return 2'h2;
      if (fmt == FMT_LONG || fmt == FMT_FLOAT) return 2'h1;
      return 2'h0;
   endfunction

   // Number of slots of a kind
   function automatic logic [7:0] kind_count(input logic [2:0] kind);
      unique case (kind)
         K_CHAN: return CHAN_COUNT;
         K_TOTAL: return TOTAL_COUNT;
         K_TIMER: return TIMER_COUNT;
         K_ALARM: return ALARM_COUNT;
         K_OUT: return OUT_COUNT;
         K_IN: return IN_COUNT;
         default: return 8'h00;
      endcase
   endfunction

endpackage

// [rtl/pv_address_decoder.sv]
// Address decoder from a Modbus address to slot kind, index and word
`timescale 1ns/1ns
module pv_address_decoder
   import pv_map_pkg::*;
(
   input wire logic [15:0] addr,
   input wire logic coil,
   output logic hit,
   output logic [2:0] kind,
   output logic [7:0] index,
   output logic [2:0] fmt,
   output logic [1:0] word
);

   // Address within base and the kind's slot count at this stride
   function automatic logic in_span(input logic [15:0] a,
      input logic [15:0] base, input logic [1:0] sh,
      input logic [2:0] k);
      logic [15:0] off;
      off = a - base;
      return (a >= base) && ((off >> sh) < {8'h00, kind_count(k)});
   endfunction

   always_comb begin
      logic [15:0] off;
      off = 16'h0000;
      hit = 1'b0;
      kind = K_CHAN;
      index = 8'h00;
      fmt = FMT_SHORT;
      word = 2'h0;
      if (coil) begin
         for (int i = 0; i < BIT_ROWS; i++) begin
            if (!hit && in_span(addr, BIT_BASE[i], 2'h0, BIT_KIND[i])) begin
               off = addr - BIT_BASE[i];
               hit = 1'b1;
               kind = BIT_KIND[i];
               fmt = FMT_BIT;
               index = off[7:0];
            end
         end
      end else begin
         for (int i = 0; i < ROWS; i++) begin
            if (!hit && in_span(addr, ROW_BASE[i], fmt_shift(ROW_FMT[i]),
                  ROW_KIND[i])) begin
               off = addr - ROW_BASE[i];
               hit = 1'b1;
               kind = ROW_KIND[i];
               fmt = ROW_FMT[i];
               index = 8'(off >> fmt_shift(ROW_FMT[i]));
               word = off[1:0] & ((2'h1 << fmt_shift(ROW_FMT[i])) - 2'h1);
            end
         end
      end
   end

endmodule

// [rtl/process_value_modbus_map.sv]
// Process-value Modbus map: decode, present values, hold input slots
//
// How it works
// - Wire addresses zero-based; numbers are address plus one.
// - Channel values at five typed address bases.
// - Registers served by functions 03 and 04.
// - Channel and output bits read 0 or 1.
// - Totals and timers read-only at typed bases.
// - Alarm status short: off, on, acknowledged.
// - Output slots read-only at five typed bases.
// - Configuration maps a parameter to each output.
// - Input slots are readable writable storage.
// - Bit, short and multiword write codes restricted.
// - Configured data type per input and output slot.
// - Write lock, unlock code then passcode, 30 s relock.
`timescale 1ns/1ns
module process_value_modbus_map
   import pv_map_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_TIMEOUT_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_exception,
   output logic [7:0] rsp_code,
   output logic [2:0] src_kind,
   output logic [7:0] src_index,
   output logic [2:0] src_fmt,
   output logic [7:0] src_param,
   output logic [2:0] src_type,
   input wire logic [63:0] src_value,
   input wire logic [63:0] alarm_on,
   input wire logic [63:0] alarm_ack,
   input wire logic protect_en,
   input wire logic [15:0] passcode,
   output logic write_unlocked,
   input wire logic cfg_we,
   input wire logic cfg_output,
   input wire logic [7:0] cfg_slot,
   input wire logic [2:0] cfg_type,
   input wire logic [7:0] cfg_param,
   input wire logic [7:0] in_rd_index,
   output logic [63:0] in_rd_value,
   output logic [2:0] in_rd_type
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_meta_n;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      phase_t phase;
      logic [2:0] kind;
      logic [7:0] idx;
      logic [2:0] fmt;
      logic [1:0] word;
      logic wr;
      logic [15:0] wdata;
      logic [7:0] code;
      logic [7:0] par;
      logic [2:0] otype;
      logic rsp_valid;
      logic [15:0] rdata;
      logic rsp_exc;
      logic [7:0] rsp_code;
      logic unlocked;
      logic armed;
      logic [29:0] idle_cnt;
      logic [198:0][63:0] in_val;
      logic [198:0][2:0] in_type;
      logic [63:0][2:0] out_type;
      logic [63:0][7:0] out_param;
      logic [63:0] in_rd_value;
      logic [2:0] in_rd_type;
   } state_t;

   state_t s;
   state_t next_s;

   // 16-bit lane of a word, most significant word at lowest address
   function automatic logic [1:0] word_lane(input logic [2:0] fmt,
      input logic [1:0] word);
      return ((2'h1 << fmt_shift(fmt)) - 2'h1) - word;
   endfunction

   // ************************************************************
   // Request decode and checks
   // ************************************************************
   logic dec_hit;
   logic [2:0] dec_kind;
   logic [7:0] dec_idx;
   logic [2:0] dec_fmt;
   logic [1:0] dec_word;
   logic coil;
   logic is_write;
   logic func_ok;
   logic prog;
   logic accept;
   logic [7:0] chk_code;

   assign coil = req_func == FN_READ_BITS || req_func == FN_READ_INBITS ||
      req_func == FN_WRITE_BIT || req_func == FN_WRITE_BITS;
   assign is_write = req_func == FN_WRITE_BIT || req_func == FN_WRITE_REG ||
      req_func == FN_WRITE_BITS || req_func == FN_WRITE_REGS;
   assign func_ok = coil || is_write || req_func == FN_READ_HOLD ||
      req_func == FN_READ_INPUT;
   assign prog = !coil &&
      (req_addr == PROG_ID_ADDR || req_addr == PROG_PASS_ADDR);
   assign req_ready = s.phase == PH_IDLE;
   assign accept = req_valid && req_ready;

   pv_address_decoder u_decoder (
      .addr(req_addr),
      .coil(coil),
      .hit(dec_hit),
      .kind(dec_kind),
      .index(dec_idx),
      .fmt(dec_fmt),
      .word(dec_word)
   );

   always_comb begin
      chk_code = EXC_NONE;
      if (!func_ok) begin
         chk_code = EXC_FUNC;
      end else if (prog) begin
         chk_code = is_write ? EXC_NONE : EXC_ADDR;
      end else if (!dec_hit) begin
         chk_code = EXC_ADDR;
      end else if (is_write && dec_kind != K_IN) begin
         chk_code = EXC_ADDR;
      end else if (req_func == FN_WRITE_REG && dec_fmt != FMT_SHORT) begin
         chk_code = EXC_FUNC;
      end else if (is_write && dec_fmt >= FMT_LONG &&
            dec_fmt != s.in_type[dec_idx]) begin
         chk_code = EXC_VALUE;
      end else if (req_func == FN_WRITE_BIT && req_wdata != COIL_ON &&
            req_wdata != COIL_OFF) begin
         chk_code = EXC_VALUE;
      end else if (is_write && protect_en && !s.unlocked) begin
         chk_code = EXC_LOCKED;
      end
   end

   // ************************************************************
   // Read value selection
   // ************************************************************
   logic [63:0] value;
   logic [1:0] alarm_code;
   logic [1:0] lane;

   always_comb begin
      alarm_code = ALARM_OFF;
      if (alarm_on[s.idx[5:0]]) begin
         alarm_code = alarm_ack[s.idx[5:0]] ? ALARM_ON_ACK : ALARM_ON;
      end
      lane = word_lane(s.fmt, s.word);
      unique case (s.kind)
         K_IN: value = s.in_val[s.idx];
         K_ALARM: value = {62'h0, alarm_code};
         default: value = src_value;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      if (cfg_we && cfg_output && cfg_slot < OUT_COUNT) begin
         next_s.out_type[cfg_slot] = cfg_type;
         next_s.out_param[cfg_slot] = cfg_param;
      end
      if (cfg_we && !cfg_output && cfg_slot < IN_COUNT) begin
         next_s.in_type[cfg_slot] = cfg_type;
      end
      next_s.in_rd_value = 64'h0;
      next_s.in_rd_type = FMT_SHORT;
      if (in_rd_index < IN_COUNT) begin
         next_s.in_rd_value = s.in_val[in_rd_index];
         next_s.in_rd_type = s.in_type[in_rd_index];
      end
      if (s.unlocked) begin
         if (s.idle_cnt >= 30'(LOCK_CYCLES - 1)) begin
            next_s.unlocked = 1'b0;
            next_s.idle_cnt = 30'h0;
         end else begin
            next_s.idle_cnt = s.idle_cnt + 30'h1;
         end
      end
      unique case (s.phase)
         PH_IDLE: begin
            if (req_valid) begin
               next_s.phase = PH_FETCH;
               next_s.kind = prog ? K_PROG : dec_kind;
               next_s.idx = prog ? {7'h0, req_addr[0]} : dec_idx;
               next_s.fmt = dec_fmt;
               next_s.word = dec_word;
               next_s.wr = is_write;
               next_s.code = chk_code;
               next_s.wdata = req_wdata;
               if (req_func == FN_WRITE_BIT) begin
                  next_s.wdata = {15'h0, req_wdata == COIL_ON};
               end
               if (req_func == FN_WRITE_BITS) begin
                  next_s.wdata = {15'h0, req_wdata[0]};
               end
               next_s.par = s.out_param[dec_idx[5:0]];
               next_s.otype = s.out_type[dec_idx[5:0]];
            end
         end
         PH_FETCH: begin
            next_s.phase = PH_IDLE;
            next_s.rsp_valid = 1'b1;
            next_s.rsp_exc = s.code != EXC_NONE;
            next_s.rsp_code = s.code;
            next_s.rdata = 16'h0;
            if (s.code == EXC_NONE && s.wr) begin
               next_s.rdata = s.wdata;
               next_s.idle_cnt = 30'h0;
               next_s.unlocked = s.unlocked;
               if (s.kind == K_PROG && s.idx == 8'h00) begin
                  next_s.armed = s.wdata == UNLOCK_CODE;
               end else if (s.kind == K_PROG) begin
                  next_s.unlocked = s.armed && s.wdata == passcode;
                  next_s.armed = 1'b0;
               end else if (s.fmt == FMT_BIT) begin
                  next_s.in_val[s.idx] = {48'h0, s.wdata};
               end else begin
                  next_s.in_val[s.idx][lane * 16 +: 16] = s.wdata;
               end
            end else if (s.code == EXC_NONE) begin
               if (s.fmt == FMT_BIT) begin
                  next_s.rdata = {15'h0, |value};
               end else begin
                  next_s.rdata = value[lane * 16 +: 16];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign rsp_valid = s.rsp_valid;
   assign rsp_data = s.rdata;
   assign rsp_exception = s.rsp_exc;
   assign rsp_code = s.rsp_code;
   assign src_kind = s.kind;
   assign src_index = s.idx;
   assign src_fmt = s.fmt;
   assign src_param = s.par;
   assign src_type = s.otype;
   assign write_unlocked = s.unlocked;
   assign in_rd_value = s.in_rd_value;
   assign in_rd_type = s.in_rd_type;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_n);

   logic done_write;
   assign done_write = s.phase == PH_FETCH && s.wr && s.code == EXC_NONE;

   property p_answer_timing;
      accept |=> !rsp_valid ##1 rsp_valid;
   endproperty
   a_answer_timing: assert property (p_answer_timing)
      else $error("answer not two cycles after request");

   property p_bit_zero_one;
      rsp_valid && !rsp_exception && s.fmt == FMT_BIT && !s.wr
         |-> rsp_data[15:1] == 15'h0;
   endproperty
   a_bit_zero_one: assert property (p_bit_zero_one)
      else $error("bit read not 0 or 1");

   property p_alarm_code;
      rsp_valid && !rsp_exception && s.kind == K_ALARM
         |-> rsp_data == {14'h0, alarm_code} && rsp_data <= 16'h0002;
   endproperty
   a_alarm_code: assert property (p_alarm_code)
      else $error("alarm status encoding wrong");

   property p_unmapped;
      accept && func_ok && !prog && !dec_hit
         |=> ##1 rsp_exception && rsp_code == EXC_ADDR;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address not answered with exception");

   property p_single_write_form;
      accept && req_func == FN_WRITE_REG && dec_hit && dec_fmt != FMT_SHORT
         && dec_kind == K_IN
         |=> ##1 rsp_exception && rsp_code == EXC_FUNC;
   endproperty
   a_single_write_form: assert property (p_single_write_form)
      else $error("function 06 accepted on multiword form");

   property p_locked_refuse;
      accept && is_write && !prog && protect_en && !s.unlocked
         |=> ##1 rsp_exception;
   endproperty
   a_locked_refuse: assert property (p_locked_refuse)
      else $error("write accepted while locked");

   property p_relock;
      s.unlocked && s.idle_cnt == 30'(LOCK_CYCLES - 1) && !done_write
         |=> !s.unlocked;
   endproperty
   a_relock: assert property (p_relock)
      else $error("protection not restored after timeout");

   property p_short_store;
      done_write && s.kind == K_IN && s.fmt == FMT_SHORT
         |=> s.in_val[$past(s.idx)][15:0] == $past(s.wdata);
   endproperty
   a_short_store: assert property (p_short_store)
      else $error("input slot short not stored");

   property p_ro_write;
      accept && is_write && dec_hit && !prog && dec_kind != K_IN
         |=> ##1 rsp_exception && rsp_code == EXC_ADDR;
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write to read-only value accepted");

   c_read_ok: cover property (rsp_valid && !rsp_exception && !s.wr);
   c_write_ok: cover property (done_write && s.kind == K_IN);
   c_unlock: cover property (!s.unlocked ##1 s.unlocked);
   c_exception: cover property (rsp_valid && rsp_exception);

endmodule

// [dv/pv_core_model.sv]
// Process core model that answers value fetches of the map
`timescale 1ns/1ns
module pv_core_model
   import pv_map_pkg::*;
(
   input wire logic [2:0] src_kind,
   input wire logic [7:0] src_index,
   input wire logic [2:0] src_fmt,
   input wire logic [7:0] src_param,
   input wire logic zero,
   output logic [63:0] src_value
);
   // Fields of the fetch are spread over all four words
   assign src_value = zero ? 64'h0 : {5'h0, src_kind, src_index, 5'h0,
      src_fmt, src_kind == K_OUT ? src_param : 8'h00, 8'hA5, src_index,
      src_index, 5'h0, src_kind};
endmodule

// [dv/tb.sv]
// Self-checking bench for the process-value Modbus map
`timescale 1ns/1ns
module tb;
   import pv_map_pkg::*;
   localparam int LC = 50;
   logic clk = 0, rst_n = 0, req_valid = 0, protect_en = 0, cfg_we = 0;
   logic cfg_output = 0, zero = 0;
   logic [7:0] req_func = 0, cfg_slot = 0, cfg_param = 0, in_rd_index = 0;
   logic [15:0] req_addr = 0, req_wdata = 0, passcode = 16'h2B7D, a, d;
   logic [2:0] cfg_type = 0, k, f;
   logic [63:0] alarm_on = 0, alarm_ack = 0, v;
   wire logic req_ready, rsp_valid, rsp_exception, write_unlocked;
   wire logic [15:0] rsp_data;
   wire logic [7:0] rsp_code, src_index, src_param;
   wire logic [2:0] src_kind, src_fmt, src_type, in_rd_type;
   wire logic [63:0] src_value, in_rd_value;
   logic [24:0] q [$];
   logic [63:0] mem [199] = '{default: '0};
   logic [7:0] outp [64];
   logic [2:0] otyp [64];
   int cnt [6] = '{99, 32, 32, 64, 64, 199};
   int n_fail = 0, n_checks = 0, i, sh, w, n;
   always #25 clk = ~clk;
   process_value_modbus_map #(.LOCK_CYCLES(LC)) u_process_value_modbus_map (
      .clk, .rst_n, .req_valid, .req_ready, .req_func, .req_addr, .req_wdata,
      .rsp_valid, .rsp_data, .rsp_exception, .rsp_code, .src_kind,
      .src_index, .src_fmt, .src_param, .src_type, .src_value, .alarm_on,
      .alarm_ack, .protect_en, .passcode, .write_unlocked, .cfg_we,
      .cfg_output, .cfg_slot, .cfg_type, .cfg_param, .in_rd_index,
      .in_rd_value, .in_rd_type);
   pv_core_model u_pv_core_model (.src_kind, .src_index, .src_fmt,
      .src_param, .zero, .src_value);
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ************************************************************
   // Answer monitor
   // ************************************************************
   always @(negedge clk) if (rsp_valid === 1'b1) begin
      if (q.size() == 0) chk("spare answer", 1, 0);
      else chk("answer", {rsp_exception, rsp_code, rsp_data}, q.pop_front());
   end
   task automatic acc(logic [7:0] fn, logic [15:0] ad, wd, logic [7:0] c,
      logic [15:0] e);
      int t;
      q.push_back({c != 8'h00, c, c != 8'h00 ? 16'h0 : e});
      @(negedge clk);
      req_valid = 1;
      req_func = fn;
      req_addr = ad;
      req_wdata = wd;
      t = 0;
      while (req_ready !== 1'b1 && t < 20) begin
         @(negedge clk);
         t++;
      end
      @(negedge clk);
      chk("ready", req_ready, 0);
      req_valid = 0;
   endtask
   task automatic cfg(logic o, logic [7:0] s, logic [2:0] t, logic [7:0] p);
      @(negedge clk);
      cfg_we = 1;
      cfg_output = o;
      cfg_slot = s;
      cfg_type = t;
      cfg_param = p;
      @(negedge clk);
      cfg_we = 0;
   endtask
   function automatic logic [63:0] val(logic [2:0] k, logic [7:0] i, p);
      return {5'h0, k, i, 5'h0, f, k == K_OUT ? p : 8'h00, 8'hA5, i, i, 5'h0, k};
   endfunction
   function automatic int shf(logic [2:0] f);
      return f >= FMT_DOUBLE ? 2 : f >= FMT_LONG ? 1 : 0;
   endfunction
   function automatic logic [15:0] wsel(logic [63:0] v, int sh, w);
      return v[16 * ((1 << sh) - 1 - w) +: 16];
   endfunction
   initial begin
      #2_000_000;
      n_fail++;
      $display("unexpected timeout");
      give_verdict;
   end
   initial begin
      void'($urandom(32'h84DC563B));
      alarm_on = {$urandom, $urandom};
      alarm_ack = alarm_on & {$urandom, $urandom};
      repeat (16) @(negedge clk);
      rst_n = 1;
      repeat (4) @(negedge clk);
      chk("unlocked", write_unlocked, 0);
      for (int j = 0; j < 64; j++) begin
         outp[j] = 8'($urandom);
         otyp[j] = 3'($urandom_range(5));
         cfg(1, 8'(j), otyp[j], outp[j]);
      end
      for (int r = 21; r < 25; r++) begin
         f = ROW_FMT[r];
         sh = shf(f);
         i = r;
         a = ROW_BASE[r] + 16'(i << sh);
         acc(FN_WRITE_REGS, a, 16'h1, EXC_VALUE, 0);
         cfg(0, 8'(i), f, 0);
         acc(FN_WRITE_REG, a, 16'h1, EXC_FUNC, 0);
         for (w = 0; w < (1 << sh); w++) begin
            d = 16'($urandom);
            acc(FN_WRITE_REGS, a + 16'(w), d, EXC_NONE, d);
            mem[i][16 * ((1 << sh) - 1 - w) +: 16] = d;
         end
         in_rd_index = 8'(i);
         repeat (3) @(negedge clk);
         chk("slot", in_rd_value, mem[i]);
         chk("slot type", in_rd_type, f);
      end
      i = $urandom_range(198);
      d = 16'($urandom);
      acc(FN_WRITE_REG, 16'h17D4 + 16'(i), d, EXC_NONE, d);
      mem[i][15:0] = d;
      acc(FN_WRITE_BIT, 16'h17D4, COIL_ON, EXC_NONE, 1);
      acc(FN_READ_BITS, 16'h17D4, 0, EXC_NONE, 1);
      acc(FN_WRITE_BITS, 16'h17D4, 16'h2, EXC_NONE, 0);
      acc(FN_READ_INBITS, 16'h17D4, 0, EXC_NONE, 0);
      acc(FN_WRITE_BIT, 16'h17D5, 16'h1234, EXC_VALUE, 0);
      mem[0] = 0;
      in_rd_index = 8'hC7;
      repeat (3) @(negedge clk);
      chk("slot none", in_rd_value, 0);
      $display("test writes done");
      for (int r = 0; r < 50; r++) begin
         k = ROW_KIND[r % 25];
         f = ROW_FMT[r % 25];
         sh = shf(f);
         n = cnt[k];
         i = r < 25 ? $urandom_range(n - 1) : n - 1;
         w = $urandom_range((1 << sh) - 1);
         a = ROW_BASE[r % 25] + 16'(i << sh) + 16'(w);
         v = k == K_IN ? mem[i] : val(k, 8'(i), outp[i % 64]);
         d = k == K_ALARM ? {14'h0, alarm_ack[i], alarm_on[i] & ~alarm_ack[i]}
            : wsel(v, sh, w);
         acc(r < 25 ? FN_READ_HOLD : FN_READ_INPUT, a, 0, EXC_NONE, d);
         if (k == K_OUT) chk("out type", src_type, otyp[i]);
         a = ROW_BASE[r % 25] + 16'(n << sh);
         acc(FN_READ_HOLD, a, 0, EXC_ADDR, 0);
      end
      acc(FN_READ_INBITS, 16'h1043, 0, EXC_NONE, 1);
      repeat (3) @(negedge clk);
      zero = 1;
      acc(FN_READ_BITS, 16'h0064 + 16'(i % 99), 0, EXC_NONE, 0);
      acc(8'h07, 16'h0064, 0, EXC_FUNC, 0);
      acc(FN_WRITE_REG, 16'h1004, 1, EXC_ADDR, 0);
      acc(FN_READ_HOLD, PROG_ID_ADDR, 0, EXC_ADDR, 0);
      $display("test reads done");
      repeat (3) @(negedge clk);
      zero = 0;
      protect_en = 1;
      acc(FN_WRITE_REG, 16'h17D4, 16'h9, EXC_LOCKED, 0);
      acc(FN_WRITE_REG, PROG_ID_ADDR, UNLOCK_CODE, EXC_NONE, 1);
      acc(FN_WRITE_REG, PROG_PASS_ADDR, ~passcode, EXC_NONE, ~passcode);
      repeat (3) @(negedge clk);
      chk("unlocked", write_unlocked, 0);
      acc(FN_WRITE_REG, PROG_ID_ADDR, UNLOCK_CODE, EXC_NONE, 1);
      acc(FN_WRITE_REGS, PROG_PASS_ADDR, passcode, EXC_NONE, passcode);
      repeat (3) @(negedge clk);
      chk("unlocked", write_unlocked, 1);
      acc(FN_WRITE_REG, 16'h17D4, 16'h9, EXC_NONE, 16'h9);
      repeat (LC + 10) @(negedge clk);
      chk("unlocked", write_unlocked, 0);
      acc(FN_WRITE_REG, 16'h17D4, 16'h9, EXC_LOCKED, 0);
      repeat (5) @(negedge clk);
      chk("pending answers", q.size(), 0);
      $display("test lock done");
      give_verdict;
   end
endmodule
